// ===== rpm_pkg.sv
// rpm_pkg: register map, field layout, reset values and timing for the rx port monitor
package rpm_pkg;

    // ==============================================================
    // register offsets, one copy of each per receive port
    // ==============================================================
    localparam logic [7:0] RPM_ADDR_LINE_COUNT_HIGH = 8'h73;
    localparam logic [7:0] RPM_ADDR_LINE_COUNT_LOW = 8'h74;
    localparam logic [7:0] RPM_ADDR_LINE_LENGTH_HIGH = 8'h75;
    localparam logic [7:0] RPM_ADDR_LINE_LENGTH_LOW = 8'h76;
    localparam logic [7:0] RPM_ADDR_FREQ_DETECT_CTL = 8'h77;
    localparam logic [7:0] RPM_ADDR_MESSAGE_SCRATCH_0 = 8'h78;
    localparam logic [7:0] RPM_ADDR_MESSAGE_SCRATCH_1 = 8'h79;

    // ==============================================================
    // reset values
    // ==============================================================
    localparam logic [7:0] RPM_RST_FREQ_DETECT_CTL = 8'hc5;
    localparam logic [7:0] RPM_RST_MESSAGE_SCRATCH_0 = 8'h00;
    localparam logic [7:0] RPM_RST_MESSAGE_SCRATCH_1 = 8'h01;
    localparam logic [15:0] RPM_RST_MEASURE = 16'h0000;
    localparam logic [7:0] RPM_READ_ZERO = 8'h00;

    // ==============================================================
    // fields of clock_frequency_detect_control
    // ==============================================================
    localparam int RPM_HYST_MSB = 7;
    localparam int RPM_HYST_LSB = 6;
    localparam int RPM_STABLE_MSB = 5;
    localparam int RPM_STABLE_LSB = 4;
    localparam int RPM_LOW_MSB = 3;
    localparam int RPM_LOW_LSB = 0;

    // ==============================================================
    // timing: 40 us base stability window, larger codes are multiples
    // ==============================================================
    localparam int RPM_CLK_PERIOD_NS = 10;
    localparam int RPM_STABLE_BASE_NS = 40000;
    localparam int RPM_STABLE_BASE_CYC = RPM_STABLE_BASE_NS / RPM_CLK_PERIOD_NS;
    // shift amounts for codes 00/01/10/11: x1 (40us), x2 (80us), x8 (320us), x32 (1.28ms)
    localparam int RPM_STABLE_SHIFT_0 = 0;
    localparam int RPM_STABLE_SHIFT_1 = 1;
    localparam int RPM_STABLE_SHIFT_2 = 3;
    localparam int RPM_STABLE_SHIFT_3 = 5;
    localparam int RPM_STABLE_MAX_MULT = 32;

endpackage : rpm_pkg

// ===== rpm_freq_detect.sv
// rpm_freq_detect: per-port link clock frequency detector with hysteresis and stability timer
module rpm_freq_detect
    import rpm_pkg::*;
#(
    parameter int FREQ_W = 8,
    parameter int STABLE_BASE_CYC = RPM_STABLE_BASE_CYC,
    parameter int CNT_W = $clog2(STABLE_BASE_CYC * RPM_STABLE_MAX_MULT + 1)
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // control fields
    input wire logic [1:0] frequency_hysteresis_mhz,
    input wire logic [1:0] frequency_stable_time_select,
    input wire logic [3:0] frequency_low_limit_mhz,
    // raw measurement
    input wire logic freq_meas_valid,
    input wire logic [FREQ_W-1:0] freq_meas_mhz,
    // results
    output logic [FREQ_W-1:0] freq_stored_mhz,
    output logic freq_stable,
    output logic no_link_clock_flag
);

    // ==============================================================
    // hysteresis compare
    // ==============================================================
    logic [FREQ_W-1:0] diff;
    logic store_now;
    logic [CNT_W-1:0] stable_cnt_reg;
    logic [CNT_W-1:0] threshold;
    logic [CNT_W-1:0] base;

    assign diff = (freq_meas_mhz > freq_stored_mhz) ? freq_meas_mhz - freq_stored_mhz
                                                    : freq_stored_mhz - freq_meas_mhz;
    assign store_now = freq_meas_valid && (diff > FREQ_W'(frequency_hysteresis_mhz));
    assign base = CNT_W'(STABLE_BASE_CYC);

    always_comb begin
        unique case (frequency_stable_time_select)
            2'h0: threshold = base << RPM_STABLE_SHIFT_0;
            2'h1: threshold = base << RPM_STABLE_SHIFT_1;
            2'h2: threshold = base << RPM_STABLE_SHIFT_2;
            2'h3: threshold = base << RPM_STABLE_SHIFT_3;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            freq_stored_mhz <= '0;
        end else if (store_now) begin
            freq_stored_mhz <= freq_meas_mhz;
        end
    end

    // ==============================================================
    // stability timer: restarts whenever the stored value moves
    // ==============================================================
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stable_cnt_reg <= '0;
        end else if (store_now) begin
            stable_cnt_reg <= '0;
        end else if (stable_cnt_reg < threshold) begin
            stable_cnt_reg <= stable_cnt_reg + CNT_W'(1);
        end
    end

    // a dead clock cannot be called settled, whatever the timer says
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            freq_stable <= 1'b0;
        end else begin
            freq_stable <= !store_now && (stable_cnt_reg >= threshold)
                && !no_link_clock_flag;
        end
    end

    // ==============================================================
    // low-frequency limit on the latest raw measurement
    // ==============================================================
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            no_link_clock_flag <= 1'b1;
        end else if (freq_meas_valid) begin
            no_link_clock_flag <= freq_meas_mhz < FREQ_W'(frequency_low_limit_mhz);
        end
    end

endmodule : rpm_freq_detect

// ===== rpm_rx_port_monitor.sv
// rpm_rx_port_monitor: per receive port line length/count, frequency detect control and mailboxes
// Functional notes
// - one register copy per port, selected by port select
// - line length of last frame, high/low bytes
// - report final line of frame when lengths vary
// - interrupt enable set freezes length until read
// - high byte read latches matching low byte
// - store frequency only beyond hysteresis band
// - stable after selectable time within band
// - no-clock flag when frequency below limit
// - two read/write mailbox bytes, reset 0x00/0x01
// - hysteresis and timer signal settled link clock
// - line count freezes until read likewise
module rpm_rx_port_monitor
    import rpm_pkg::*;
#(
    parameter int NUM_PORTS = 4,
    parameter int PORT_W = 2,
    parameter int LEN_W = 16,
    parameter int FREQ_W = 8,
    parameter int STABLE_BASE_CYC = RPM_STABLE_BASE_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register access from the i2c controller
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [PORT_W-1:0] rx_port_select,
    // interrupt enables held in the interrupt controller
    input wire logic [NUM_PORTS-1:0] line_length_change_irq_enable,
    input wire logic [NUM_PORTS-1:0] line_count_change_irq_enable,
    // video timing per port
    input wire logic [NUM_PORTS-1:0] line_done,
    input wire logic [NUM_PORTS*LEN_W-1:0] line_len_meas,
    input wire logic [NUM_PORTS-1:0] frame_done,
    // link clock frequency measurement per port
    input wire logic [NUM_PORTS-1:0] freq_meas_valid,
    input wire logic [NUM_PORTS*FREQ_W-1:0] freq_meas_mhz,
    // detector results per port
    output logic [NUM_PORTS*FREQ_W-1:0] freq_stored_mhz,
    output logic [NUM_PORTS-1:0] freq_stable,
    output logic [NUM_PORTS-1:0] no_link_clock_flag
);

    // ==============================================================
    // per-port storage
    // ==============================================================
    logic [7:0] freq_ctl_reg [NUM_PORTS];
    logic [7:0] scratch0_reg [NUM_PORTS];
    logic [7:0] scratch1_reg [NUM_PORTS];
    logic [LEN_W-1:0] line_length_reg [NUM_PORTS];
    logic [7:0] length_low_shadow_reg [NUM_PORTS];
    logic [LEN_W-1:0] line_count_reg [NUM_PORTS];
    logic [7:0] count_low_shadow_reg [NUM_PORTS];
    logic [7:0] read_next;

    // ==============================================================
    // writable registers: only the selected port's copy takes a write
    // ==============================================================
    always_ff @(posedge clk_sys) begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (rst) begin
                freq_ctl_reg[p] <= RPM_RST_FREQ_DETECT_CTL;
                scratch0_reg[p] <= RPM_RST_MESSAGE_SCRATCH_0;
                scratch1_reg[p] <= RPM_RST_MESSAGE_SCRATCH_1;
            end else if (reg_wr && (rx_port_select == PORT_W'(p))) begin
                if (reg_addr == RPM_ADDR_FREQ_DETECT_CTL) begin
                    freq_ctl_reg[p] <= reg_wdata;
                end
                if (reg_addr == RPM_ADDR_MESSAGE_SCRATCH_0) begin
                    scratch0_reg[p] <= reg_wdata;
                end
                if (reg_addr == RPM_ADDR_MESSAGE_SCRATCH_1) begin
                    scratch1_reg[p] <= reg_wdata;
                end
            end
        end
    end

    // ==============================================================
    // per-port measurement capture and frequency detector
    // ==============================================================
    for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
        logic port_hit;
        logic len_high_read;
        logic cnt_high_read;
        logic [LEN_W-1:0] meas;
        logic [LEN_W-1:0] last_line_reg;
        logic [LEN_W-1:0] frame_len;
        logic len_frozen_reg;
        logic len_publish;
        logic [LEN_W-1:0] running_cnt_reg;
        logic [LEN_W-1:0] frame_cnt;
        logic cnt_frozen_reg;
        logic cnt_publish;

        assign port_hit = rx_port_select == PORT_W'(i);
        assign len_high_read = reg_rd && port_hit && (reg_addr == RPM_ADDR_LINE_LENGTH_HIGH);
        assign cnt_high_read = reg_rd && port_hit && (reg_addr == RPM_ADDR_LINE_COUNT_HIGH);
        assign meas = line_len_meas[i*LEN_W +: LEN_W];

        // a line ending in the same cycle as the frame is the frame's final line
        assign frame_len = line_done[i] ? meas : last_line_reg;
        // a read in the same cycle as the frame end lets the new value in
        assign len_publish = frame_done[i] && (!len_frozen_reg || len_high_read);

        always_ff @(posedge clk_sys) begin
            if (rst) begin
                last_line_reg <= RPM_RST_MEASURE;
            end else if (line_done[i]) begin
                last_line_reg <= meas;
            end
        end

        always_ff @(posedge clk_sys) begin
            if (rst) begin
                line_length_reg[i] <= RPM_RST_MEASURE;
            end else if (len_publish) begin
                line_length_reg[i] <= frame_len;
            end
        end

        // set wins over the clearing read
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                len_frozen_reg <= 1'b0;
            end else if (len_publish && line_length_change_irq_enable[i]) begin
                len_frozen_reg <= 1'b1;
            end else if (len_high_read || !line_length_change_irq_enable[i]) begin
                len_frozen_reg <= 1'b0;
            end
        end

        always_ff @(posedge clk_sys) begin
            if (rst) begin
                length_low_shadow_reg[i] <= RPM_READ_ZERO;
            end else if (len_high_read) begin
                length_low_shadow_reg[i] <= line_length_reg[i][7:0];
            end
        end

        // line count: counts line ends between frame ends
        assign frame_cnt = running_cnt_reg + LEN_W'(line_done[i]);
        assign cnt_publish = frame_done[i] && (!cnt_frozen_reg || cnt_high_read);

        always_ff @(posedge clk_sys) begin
            if (rst) begin
                running_cnt_reg <= RPM_RST_MEASURE;
            end else if (frame_done[i]) begin
                running_cnt_reg <= RPM_RST_MEASURE;
            end else if (line_done[i]) begin
                running_cnt_reg <= frame_cnt;
            end
        end

        always_ff @(posedge clk_sys) begin
            if (rst) begin
                line_count_reg[i] <= RPM_RST_MEASURE;
            end else if (cnt_publish) begin
                line_count_reg[i] <= frame_cnt;
            end
        end

        always_ff @(posedge clk_sys) begin
            if (rst) begin
                cnt_frozen_reg <= 1'b0;
            end else if (cnt_publish && line_count_change_irq_enable[i]) begin
                cnt_frozen_reg <= 1'b1;
            end else if (cnt_high_read || !line_count_change_irq_enable[i]) begin
                cnt_frozen_reg <= 1'b0;
            end
        end

        always_ff @(posedge clk_sys) begin
            if (rst) begin
                count_low_shadow_reg[i] <= RPM_READ_ZERO;
            end else if (cnt_high_read) begin
                count_low_shadow_reg[i] <= line_count_reg[i][7:0];
            end
        end

        rpm_freq_detect #(
            .FREQ_W(FREQ_W),
            .STABLE_BASE_CYC(STABLE_BASE_CYC)
        ) u_freq_detect (
            .clk_sys(clk_sys),
            .rst(rst),
            .frequency_hysteresis_mhz(freq_ctl_reg[i][RPM_HYST_MSB:RPM_HYST_LSB]),
            .frequency_stable_time_select(freq_ctl_reg[i][RPM_STABLE_MSB:RPM_STABLE_LSB]),
            .frequency_low_limit_mhz(freq_ctl_reg[i][RPM_LOW_MSB:RPM_LOW_LSB]),
            .freq_meas_valid(freq_meas_valid[i]),
            .freq_meas_mhz(freq_meas_mhz[i*FREQ_W +: FREQ_W]),
            .freq_stored_mhz(freq_stored_mhz[i*FREQ_W +: FREQ_W]),
            .freq_stable(freq_stable[i]),
            .no_link_clock_flag(no_link_clock_flag[i])
        );
    end

    // ==============================================================
    // read path: selected port's copy, one cycle of latency
    // ==============================================================
    always_comb begin
        read_next = RPM_READ_ZERO;
        unique case (reg_addr)
            RPM_ADDR_LINE_COUNT_HIGH: read_next = line_count_reg[rx_port_select][15:8];
            RPM_ADDR_LINE_COUNT_LOW: read_next = count_low_shadow_reg[rx_port_select];
            RPM_ADDR_LINE_LENGTH_HIGH: read_next = line_length_reg[rx_port_select][15:8];
            // low byte comes from the copy taken at the last high-byte read
            RPM_ADDR_LINE_LENGTH_LOW: read_next = length_low_shadow_reg[rx_port_select];
            RPM_ADDR_FREQ_DETECT_CTL: read_next = freq_ctl_reg[rx_port_select];
            RPM_ADDR_MESSAGE_SCRATCH_0: read_next = scratch0_reg[rx_port_select];
            RPM_ADDR_MESSAGE_SCRATCH_1: read_next = scratch1_reg[rx_port_select];
            default: read_next = RPM_READ_ZERO;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= RPM_READ_ZERO;
        end else if (reg_rd) begin
            reg_rdata <= read_next;
        end
    end

endmodule : rpm_rx_port_monitor

// ===== rpm_i2c_ctrl_model.sv
// rpm_i2c_ctrl_model: register access master standing in for the i2c controller
module rpm_i2c_ctrl_model (
    // clock and read data
    input wire logic clk_sys,
    input wire logic [7:0] reg_rdata,
    // register access
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    output logic [1:0] rx_port_select
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // access tasks
    // ==========================================================
    initial begin
        {reg_addr, reg_wr, reg_rd, reg_wdata, rx_port_select} = '0;
    end
    // idle address and write data lines carry inverted leftovers so stale values cannot be relied on; port select holds
    task automatic rd(input logic [1:0] p, input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        #1;
        rx_port_select = p;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask : rd
    // write followed at once by a read of the same place
    task automatic wr_rd(input logic [1:0] p, input logic [7:0] a, input logic [7:0] w,
                         output logic [7:0] d);
        @(posedge clk_sys);
        #1;
        rx_port_select = p;
        reg_addr = a;
        reg_wdata = w;
        reg_wr = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~w;
        reg_rd = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask : wr_rd
endmodule : rpm_i2c_ctrl_model

// ===== rpm_rx_port_monitor_checker.sv
// rpm_rx_port_monitor_checker: port-level assertions for the rx port monitor
module rpm_rx_port_monitor_checker #(
    parameter int NUM_PORTS = 4,
    parameter int PORT_W = 2,
    parameter int FREQ_W = 8,
    parameter int STABLE_BASE_CYC = 8
) (
    // clock, reset and register access
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [PORT_W-1:0] rx_port_select,
    // frequency detector
    input wire logic [NUM_PORTS-1:0] freq_meas_valid,
    input wire logic [NUM_PORTS*FREQ_W-1:0] freq_meas_mhz,
    input wire logic [NUM_PORTS*FREQ_W-1:0] freq_stored_mhz,
    input wire logic [NUM_PORTS-1:0] freq_stable,
    input wire logic [NUM_PORTS-1:0] no_link_clock_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // helpers, port 0 detector only
    // ==========================================================
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    logic [FREQ_W-1:0] m0;
    logic [FREQ_W-1:0] s0;
    logic [FREQ_W-1:0] s0_q;
    logic nl_q;
    logic jump0;
    int quiet_cnt;
    assign m0 = freq_meas_mhz[FREQ_W-1:0];
    assign s0 = freq_stored_mhz[FREQ_W-1:0];
    // 3 MHz is the widest band, so a bigger step must always be stored
    assign jump0 = (int'(m0) > int'(s0) + 3) || (int'(s0) > int'(m0) + 3);
    always_ff @(posedge clk_sys) begin
        s0_q <= s0;
        nl_q <= no_link_clock_flag[0];
        if (rst || s0 != s0_q || no_link_clock_flag[0] != nl_q) begin
            quiet_cnt <= 0;
        end else if (quiet_cnt < STABLE_BASE_CYC * 32 + 4) begin
            quiet_cnt <= quiet_cnt + 1;
        end
    end
    // ==========================================================
    // assertions
    // ==========================================================
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (reg_rd && !(reg_addr inside {[8'h73:8'h79]})
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_write_readback: assert property (reg_wr && reg_addr inside {[8'h77:8'h79]}
        ##1 reg_rd && $stable(reg_addr) && $stable(rx_port_select)
        |=> reg_rdata == $past(reg_wdata, 2)) else $error("written value not read back");
    a_jump_stored: assert property (freq_meas_valid[0] && jump0 |=> s0 == $past(m0))
        else $error("large frequency step not stored");
    a_equal_kept: assert property (freq_meas_valid[0] && m0 == s0 |=> $stable(s0))
        else $error("equal measurement changed store");
    a_store_unsettles: assert property ($changed(s0) |-> !freq_stable[0])
        else $error("stable kept across a store");
    a_stable_not_early: assert property ($rose(freq_stable[0])
        |-> quiet_cnt >= STABLE_BASE_CYC) else $error("stable raised too early");
    a_stable_in_time: assert property (quiet_cnt >= STABLE_BASE_CYC * 32 + 4
        && !no_link_clock_flag[0] |-> freq_stable[0]) else $error("stable never raised");
    a_fast_clock_seen: assert property (freq_meas_valid[0] && m0 >= 8'h10
        |=> !no_link_clock_flag[0]) else $error("no clock flag on fast clock");
endmodule : rpm_rx_port_monitor_checker

bind rpm_rx_port_monitor rpm_rx_port_monitor_checker #(.NUM_PORTS(NUM_PORTS), .PORT_W(PORT_W),
    .FREQ_W(FREQ_W), .STABLE_BASE_CYC(STABLE_BASE_CYC)) i_rpm_rx_port_monitor_checker (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_port_select(rx_port_select),
    .freq_meas_valid(freq_meas_valid), .freq_meas_mhz(freq_meas_mhz),
    .freq_stored_mhz(freq_stored_mhz), .freq_stable(freq_stable),
    .no_link_clock_flag(no_link_clock_flag));

// ===== rpm_rx_port_monitor_tb_top.sv
// rpm_rx_port_monitor_tb_top: register-level tests of the rx port monitor
module rpm_rx_port_monitor_tb_top import rpm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(name, exp, got) \
        total_checks++; \
        if ((got) !== (exp)) begin \
            $display("wrong value %s expected %h seen %h", name, exp, got); \
            num_errors++; \
        end
    // ==========================================================
    // signals and instances
    // ==========================================================
    localparam logic [7:0] LH = RPM_ADDR_LINE_LENGTH_HIGH;
    localparam logic [7:0] LL = RPM_ADDR_LINE_LENGTH_LOW;
    localparam logic [7:0] CH = RPM_ADDR_LINE_COUNT_HIGH;
    localparam logic [7:0] CL = RPM_ADDR_LINE_COUNT_LOW;
    localparam logic [7:0] CTL = RPM_ADDR_FREQ_DETECT_CTL;
    logic clk_sys;
    logic rst;
    logic [7:0] reg_addr;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [1:0] port_sel;
    logic [3:0] len_ie;
    logic [3:0] cnt_ie;
    logic [3:0] line_done;
    logic [63:0] line_len;
    logic [3:0] frame_done;
    logic [3:0] fvalid;
    logic [31:0] fmeas;
    logic [31:0] fstored;
    logic [3:0] fstable;
    logic [3:0] nolink;
    logic [7:0] rd_val;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int mult[4] = '{1, 2, 8, 32};
    rpm_rx_port_monitor #(.STABLE_BASE_CYC(8)) i_rpm_rx_port_monitor (.clk_sys(clk_sys),
        .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_port_select(port_sel),
        .line_length_change_irq_enable(len_ie), .line_count_change_irq_enable(cnt_ie),
        .line_done(line_done), .line_len_meas(line_len), .frame_done(frame_done),
        .freq_meas_valid(fvalid), .freq_meas_mhz(fmeas), .freq_stored_mhz(fstored),
        .freq_stable(fstable), .no_link_clock_flag(nolink));
    rpm_i2c_ctrl_model i_rpm_i2c_ctrl_model (.clk_sys(clk_sys), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .rx_port_select(port_sel));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end
    // ==========================================================
    // tasks
    // ==========================================================
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic chk_rd(input logic [1:0] p, input logic [7:0] a, input logic [7:0] e);
        i_rpm_i2c_ctrl_model.rd(p, a, rd_val);
        `CHK("read data", e, rd_val)
    endtask : chk_rd
    task automatic wr_chk(input logic [1:0] p, input logic [7:0] a, input logic [7:0] w,
                          input logic [7:0] e);
        i_rpm_i2c_ctrl_model.wr_rd(p, a, w, rd_val);
        `CHK("read back", e, rd_val)
    endtask : wr_chk
    // one video line or frame end on port 0; the bus is scrambled when idle
    task automatic line(input logic [15:0] n);
        @(posedge clk_sys);
        #1;
        line_done[0] = 1'b1;
        line_len[15:0] = n;
        @(posedge clk_sys);
        #1;
        line_done[0] = 1'b0;
        line_len[15:0] = ~n;
    endtask : line
    task automatic frame();
        @(posedge clk_sys);
        #1;
        frame_done[0] = 1'b1;
        @(posedge clk_sys);
        #1;
        frame_done[0] = 1'b0;
    endtask : frame
    task automatic meas(input logic [7:0] v, input logic [7:0] e, input logic nl);
        @(posedge clk_sys);
        #1;
        fvalid[0] = 1'b1;
        fmeas[7:0] = v;
        @(posedge clk_sys);
        #1;
        fvalid[0] = 1'b0;
        fmeas[7:0] = ~v;
        @(posedge clk_sys);
        #1;
        `CHK("stored frequency", e, fstored[7:0])
        `CHK("no clock flag", nl, nolink[0])
    endtask : meas
    // ==========================================================
    // test sequence
    // ==========================================================
    initial begin
        rst = 1'b1;
        {len_ie, cnt_ie, line_done, frame_done, fvalid, line_len, fmeas} = '0;
        repeat (2) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        chk_rd(2'd0, CTL, RPM_RST_FREQ_DETECT_CTL);
        chk_rd(2'd2, RPM_ADDR_MESSAGE_SCRATCH_0, 8'h00);
        chk_rd(2'd3, RPM_ADDR_MESSAGE_SCRATCH_1, 8'h01);
        chk_rd(2'd0, LL, 8'h00);
        chk_rd(2'd0, 8'h7a, 8'h00);
        wr_chk(2'd0, LH, 8'h5a, 8'h00);
        wr_chk(2'd1, RPM_ADDR_MESSAGE_SCRATCH_1, 8'hc3, 8'hc3);
        for (int p = 0; p < 4; p++) begin
            wr_chk(p[1:0], RPM_ADDR_MESSAGE_SCRATCH_0, 8'h10 + p[7:0], 8'h10 + p[7:0]);
        end
        for (int p = 0; p < 4; p++) begin
            chk_rd(p[1:0], RPM_ADDR_MESSAGE_SCRATCH_0, 8'h10 + p[7:0]);
        end
        line(16'h1234);
        line(16'h0abc);
        frame();
        chk_rd(2'd0, LH, 8'h0a);
        chk_rd(2'd0, LL, 8'hbc);
        chk_rd(2'd0, CH, 8'h00);
        chk_rd(2'd0, CL, 8'h02);
        chk_rd(2'd1, LH, 8'h00);
        line(16'h5678);
        frame();
        chk_rd(2'd0, LH, 8'h56);
        line(16'h9a01);
        frame();
        chk_rd(2'd0, LL, 8'h78);
        chk_rd(2'd0, LH, 8'h9a);
        len_ie[0] = 1'b1;
        cnt_ie[0] = 1'b1;
        line(16'h1111);
        frame();
        line(16'h2222);
        line(16'h2222);
        frame();
        chk_rd(2'd0, LH, 8'h11);
        chk_rd(2'd0, CH, 8'h00);
        chk_rd(2'd0, CL, 8'h01);
        line(16'h3333);
        frame();
        chk_rd(2'd0, LH, 8'h33);
        // a line ending in the frame-end cycle is that frame's last line
        @(posedge clk_sys);
        #1;
        {line_done[0], frame_done[0], line_len[15:0]} = {2'b11, 16'h5566};
        @(posedge clk_sys);
        #1;
        {line_done[0], frame_done[0]} = 2'b00;
        chk_rd(2'd0, LH, 8'h55);
        chk_rd(2'd0, LL, 8'h66);
        meas(8'd50, 8'd50, 1'b0);
        meas(8'd53, 8'd50, 1'b0);
        meas(8'd54, 8'd54, 1'b0);
        wr_chk(2'd0, CTL, 8'h05, 8'h05);
        meas(8'd55, 8'd55, 1'b0);
        meas(8'd55, 8'd55, 1'b0);
        meas(8'd4, 8'd4, 1'b1);
        meas(8'd5, 8'd5, 1'b0);
        wr_chk(2'd0, CTL, 8'h0a, 8'h0a);
        meas(8'd9, 8'd9, 1'b1);
        for (int c = 0; c < 4; c++) begin
            wr_chk(2'd0, CTL, {2'b11, c[1:0], 4'h5}, {2'b11, c[1:0], 4'h5});
            meas(8'd40 + 8'(20 * c), 8'd40 + 8'(20 * c), 1'b0);
            repeat (mult[c] * 8 - 1) @(posedge clk_sys);
            #1;
            `CHK("stable early", 1'b0, fstable[0])
            @(posedge clk_sys);
            #1;
            `CHK("stable late", 1'b1, fstable[0])
        end
        repeat (20) @(posedge clk_sys);
        #1;
        `CHK("idle ports no clock", 3'b111, nolink[3:1])
        `CHK("idle ports stable", 3'b000, fstable[3:1])
        conclude();
    end
endmodule : rpm_rx_port_monitor_tb_top
